// File: verilog/bit_timer_pkg.sv
// Constants, field layout and types of the mark/space bit timer
`default_nettype none
package bit_timer_pkg;
  // ==========================================================================
  // Register indices; byte address is four times the index
  localparam logic [9:0]  IDX_COUNT_LOW   = 10'h020;
  localparam logic [9:0]  IDX_CONTROL     = 10'h021;
  localparam logic [9:0]  IDX_IRQ_STATUS  = 10'h024;
  localparam logic [9:0]  IDX_IRQ_MASK    = 10'h025;
  localparam logic [9:0]  IDX_CPU_CONFIG  = 10'h033;
  localparam int          ADDR_W          = 12;
  // ==========================================================================
  // Control register fields and CPU config divide select field
  localparam int          CTL_COUNT_HI    = 6;
  localparam int          CTL_MODE        = 4;
  localparam int          CTL_IRQ_EN      = 3;
  localparam int          CTL_DONE_FLAG   = 2;
  localparam int          CTL_DATA_BIT    = 1;
  localparam int          CTL_BUF_FLAG    = 0;
  localparam int          CFG_DIV_SEL     = 5;
  // Interrupt status / mask bits
  localparam int          IRQ_BUF_BIT     = 0;
  localparam int          IRQ_DONE_BIT    = 1;
  // ==========================================================================
  // Reset values
  localparam logic [7:0]  RST_COUNT_LOW   = 8'h00;
  localparam logic [7:0]  RST_CONTROL     = 8'h00;
  localparam logic [1:0]  RST_DIV_SEL     = 2'h0;
  localparam logic [1:0]  RST_IRQ         = 2'h0;
  // ==========================================================================
  // Interrupt vectors
  localparam logic [7:0]  VEC_DONE_EDGE   = 8'h02;
  localparam logic [7:0]  VEC_BUF_EMPTY   = 8'h04;
  localparam logic [7:0]  VEC_NONE        = 8'h00;
  // Counter limits
  localparam logic [9:0]  COUNT_MAX       = 10'h3FF;
  // ==========================================================================
  typedef enum logic [1:0] {
    MODE_OFF      = 2'b00,
    MODE_GENERIC  = 2'b01,
    MODE_RECEIVE  = 2'b10,
    MODE_TRANSMIT = 2'b11
  } mode_t;

  typedef enum logic {
    TX_IDLE = 1'b0,
    TX_RUN  = 1'b1
  } tx_state_t;

  // Crystal divide ratio chosen by the system clock divide select field
  function automatic logic [7:0] divide_ratio(input logic [1:0] sel);
    case (sel)
      2'b11:   divide_ratio = 8'h10;
      2'b10:   divide_ratio = 8'h20;
      2'b01:   divide_ratio = 8'h40;
      default: divide_ratio = 8'h80;
    endcase
  endfunction : divide_ratio
endpackage : bit_timer_pkg
`default_nettype wire

// File: verilog/proc_clock_divider.sv
// Processor clock enable: crystal divided by 16, 32, 64 or 128
`timescale 1ns/1ps
`default_nettype none
module proc_clock_divider (
  input  wire logic       clk,                          // Crystal clock
  input  wire logic       rst_b,                        // Async reset, active low
  input  wire logic [1:0] system_clock_divide_select,   // Divide select
  output var  logic       tick                          // One-cycle enable
);
  import bit_timer_pkg::*;

  logic [7:0] div_cnt_reg;
  logic [7:0] last_cnt;

  assign last_cnt = divide_ratio(system_clock_divide_select) - 8'h01;

  // ==========================================================================
  // Divider
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt_reg <= 8'h00;
      tick        <= 1'b0;
    end else if (div_cnt_reg >= last_cnt) begin
      div_cnt_reg <= 8'h00;
      tick        <= 1'b1;
    end else begin
      div_cnt_reg <= div_cnt_reg + 8'h01;
      tick        <= 1'b0;
    end
  end

  tick_spacing_a: assert property (@(posedge clk) disable iff (!rst_b)
    tick |=> !tick) else $error("divider tick lasted more than one cycle");
endmodule : proc_clock_divider
`default_nettype wire

// File: verilog/bit_timer_mark_space.sv
// Mark/space bit timer with APB register slave and interrupts
// Operation
// - Ten-bit count: low byte register plus control bits seven and six.
// - Each mark or space lasts processor clock period times count plus one.
// - Mode field: 00 off, 01 generic timer, 10 receive, 11 transmit.
// - Interrupt enable bit three lets each set flag raise its interrupt.
// - Buffer flag interrupt vectors to 0x04, done flag interrupt to 0x02.
// - Transmit and generic: done flag sets when buffer empty and count expired.
// - Receive: done flag sets on every capture pin edge.
// - Reading control register clears done and buffer flags; both read-only.
// - Transmit: data bit is one-bit buffer; taking it sets buffer flag.
// - Transmit: buffer flag means buffer empty, load next bit.
// - Receive: data bit holds edge polarity, one rising, zero falling.
// - Receive: count field holds processor cycles since previous edge.
// - Receive: interval counter overflow sets the buffer flag.
// - Processor clock is crystal divided by 16, 32, 64 or 128.
`timescale 1ns/1ps
`default_nettype none
module bit_timer_mark_space (
  input  wire logic                       clk,                 // 100 MHz crystal clock
  input  wire logic                       rst_b,               // Async reset, active low
  input  wire logic                       psel,                // APB select
  input  wire logic                       penable,             // APB enable
  input  wire logic                       pwrite,              // APB direction
  input  wire logic [bit_timer_pkg::ADDR_W-1:0] paddr,         // APB byte address
  input  wire logic [31:0]                pwdata,              // APB write data
  output var  logic [31:0]                prdata,              // APB read data
  output var  logic                       pready,              // APB ready
  output var  logic                       pslverr,             // APB error
  input  wire logic                       capture_input_pin,   // Receive edge input
  output var  logic                       tx_key,              // Transmitter keying
  output var  logic                       done_edge_irq,       // Done/edge interrupt
  output var  logic                       buffer_empty_irq,    // Buffer/overflow interrupt
  output var  logic [7:0]                 irq_vector,          // Pending vector address
  output var  logic                       irq                  // Masked sticky interrupt
);
  import bit_timer_pkg::*;

  // ==========================================================================
  // Registers and state
  logic [7:0]  count_low_reg;
  logic [1:0]  count_hi_reg;
  mode_t       mode_reg;
  logic        irq_en_reg;
  logic        done_flag_reg;
  logic        data_bit_reg;
  logic        buf_flag_reg;
  logic [1:0]  div_sel_reg;
  logic [1:0]  status_reg;
  logic [1:0]  mask_reg;
  logic        buf_full_reg;
  tx_state_t   tx_state_reg;
  logic [9:0]  down_cnt_reg;
  logic [9:0]  up_cnt_reg;
  logic        pin_prev_reg;
  logic        tick;

  logic [9:0]  reg_idx;
  logic        access;
  logic        wr_count;
  logic        wr_ctrl;
  logic        rd_ctrl;
  logic        timing_mode;
  logic        take_bit;
  logic        finish;
  logic        edge_seen;
  logic        overflow;
  logic [1:0]  irq_events;
  logic [1:0]  status_next;
  logic [7:0]  ctrl_value;
  mode_t       wr_mode;

  function automatic logic idx_mapped(input logic [9:0] idx);
    idx_mapped = (idx == IDX_COUNT_LOW) || (idx == IDX_CONTROL) || (idx == IDX_IRQ_STATUS) ||
                 (idx == IDX_IRQ_MASK) || (idx == IDX_CPU_CONFIG);
  endfunction : idx_mapped

  proc_clock_divider u_divider (
    .clk                        (clk),
    .rst_b                      (rst_b),
    .system_clock_divide_select (div_sel_reg),
    .tick                       (tick)
  );

  // ==========================================================================
  // Bus decode
  assign reg_idx  = paddr[11:2];
  assign access   = psel && penable && pready && !pslverr;
  assign wr_count = access && pwrite && (reg_idx == IDX_COUNT_LOW);
  assign wr_ctrl  = access && pwrite && (reg_idx == IDX_CONTROL);
  assign rd_ctrl  = access && !pwrite && (reg_idx == IDX_CONTROL);
  assign wr_mode  = mode_t'(pwdata[CTL_MODE +: 2]);

  assign ctrl_value = {count_hi_reg, mode_reg, irq_en_reg, done_flag_reg, data_bit_reg, buf_flag_reg};

  // ==========================================================================
  // Timer events
  assign timing_mode = (mode_reg == MODE_TRANSMIT) || (mode_reg == MODE_GENERIC);
  assign take_bit    = tick && timing_mode && buf_full_reg &&
                       ((tx_state_reg == TX_IDLE) || (down_cnt_reg == 10'h000));
  assign finish      = tick && timing_mode && !buf_full_reg &&
                       (tx_state_reg == TX_RUN) && (down_cnt_reg == 10'h000);
  assign edge_seen   = (mode_reg == MODE_RECEIVE) && (capture_input_pin != pin_prev_reg);
  assign overflow    = (mode_reg == MODE_RECEIVE) && tick && !edge_seen &&
                       (up_cnt_reg == COUNT_MAX);
  assign irq_events  = {finish || edge_seen, take_bit || overflow};
  assign status_next = (status_reg & ~((access && pwrite && reg_idx == IDX_IRQ_STATUS) ?
                        pwdata[1:0] : 2'h0)) | irq_events;

  // ==========================================================================
  // APB slave: one wait state, registered answer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && (!idx_mapped(reg_idx) || (paddr[1:0] != 2'h0));
      if (psel && penable && !pready && !pwrite) begin
        case (reg_idx)
          IDX_COUNT_LOW:  prdata <= {24'h00_0000, count_low_reg};
          IDX_CONTROL:    prdata <= {24'h00_0000, ctrl_value};
          IDX_IRQ_STATUS: prdata <= {30'h0000_0000, status_reg};
          IDX_IRQ_MASK:   prdata <= {30'h0000_0000, mask_reg};
          IDX_CPU_CONFIG: prdata <= {25'h000_0000, div_sel_reg, 5'h00};
          default:        prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================================
  // Count field: software value, or captured interval in receive mode
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_low_reg <= RST_COUNT_LOW;
      count_hi_reg  <= RST_CONTROL[CTL_COUNT_HI +: 2];
    end else if (edge_seen) begin
      count_low_reg <= up_cnt_reg[7:0];
      count_hi_reg  <= up_cnt_reg[9:8];
    end else begin
      if (wr_count) begin
        count_low_reg <= pwdata[7:0];
      end
      if (wr_ctrl) begin
        count_hi_reg <= pwdata[CTL_COUNT_HI +: 2];
      end
    end
  end

  // Configuration fields
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg    <= mode_t'(RST_CONTROL[CTL_MODE +: 2]);
      irq_en_reg  <= RST_CONTROL[CTL_IRQ_EN];
      div_sel_reg <= RST_DIV_SEL;
      mask_reg    <= RST_IRQ;
    end else begin
      if (wr_ctrl) begin
        mode_reg   <= wr_mode;
        irq_en_reg <= pwdata[CTL_IRQ_EN];
      end
      if (access && pwrite && reg_idx == IDX_CPU_CONFIG) begin
        div_sel_reg <= pwdata[CFG_DIV_SEL +: 2];
      end
      if (access && pwrite && reg_idx == IDX_IRQ_MASK) begin
        mask_reg <= pwdata[1:0];
      end
    end
  end

  // Flags: set wins over the clear by read
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      done_flag_reg <= RST_CONTROL[CTL_DONE_FLAG];
      buf_flag_reg  <= RST_CONTROL[CTL_BUF_FLAG];
    end else if (mode_reg == MODE_OFF) begin
      done_flag_reg <= 1'b0;
      buf_flag_reg  <= 1'b0;
    end else begin
      if (finish || edge_seen) begin
        done_flag_reg <= 1'b1;
      end else if (rd_ctrl) begin
        done_flag_reg <= 1'b0;
      end
      if (take_bit || overflow) begin
        buf_flag_reg <= 1'b1;
      end else if (rd_ctrl) begin
        buf_flag_reg <= 1'b0;
      end
    end
  end

  // Data bit and one-bit buffer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      data_bit_reg <= RST_CONTROL[CTL_DATA_BIT];
      buf_full_reg <= 1'b0;
    end else if (edge_seen) begin
      data_bit_reg <= capture_input_pin;
      buf_full_reg <= 1'b0;
    end else if (wr_ctrl && (wr_mode == MODE_TRANSMIT || wr_mode == MODE_GENERIC)) begin
      data_bit_reg <= pwdata[CTL_DATA_BIT];
      buf_full_reg <= 1'b1;
    end else if (!timing_mode || take_bit) begin
      buf_full_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Mark/space countdown and keying
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_state_reg <= TX_IDLE;
      down_cnt_reg <= 10'h000;
      tx_key       <= 1'b0;
    end else if (!timing_mode) begin
      tx_state_reg <= TX_IDLE;
      down_cnt_reg <= 10'h000;
      tx_key       <= 1'b0;
    end else begin
      case (tx_state_reg)
        TX_IDLE: begin
          if (take_bit) begin
            tx_state_reg <= TX_RUN;
            down_cnt_reg <= {count_hi_reg, count_low_reg};
            tx_key       <= (mode_reg == MODE_TRANSMIT) && data_bit_reg;
          end
        end
        TX_RUN: begin
          if (take_bit) begin
            down_cnt_reg <= {count_hi_reg, count_low_reg};
            tx_key       <= (mode_reg == MODE_TRANSMIT) && data_bit_reg;
          end else if (finish) begin
            tx_state_reg <= TX_IDLE;
            tx_key       <= 1'b0;
          end else if (tick) begin
            down_cnt_reg <= down_cnt_reg - 10'h001;
          end
        end
        default: tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  // Receive edge interval counter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      up_cnt_reg   <= 10'h000;
      pin_prev_reg <= 1'b0;
    end else begin
      pin_prev_reg <= capture_input_pin;
      if (mode_reg != MODE_RECEIVE || edge_seen) begin
        up_cnt_reg <= 10'h000;
      end else if (tick) begin
        up_cnt_reg <= up_cnt_reg + 10'h001;
      end
    end
  end

  // ==========================================================================
  // Interrupts
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status_reg       <= RST_IRQ;
      irq              <= 1'b0;
      done_edge_irq    <= 1'b0;
      buffer_empty_irq <= 1'b0;
      irq_vector       <= VEC_NONE;
    end else begin
      status_reg       <= status_next;
      irq              <= |(status_reg & mask_reg);
      done_edge_irq    <= irq_en_reg && done_flag_reg;
      buffer_empty_irq <= irq_en_reg && buf_flag_reg;
      if (irq_en_reg && done_flag_reg) begin
        irq_vector <= VEC_DONE_EDGE;
      end else if (irq_en_reg && buf_flag_reg) begin
        irq_vector <= VEC_BUF_EMPTY;
      end else begin
        irq_vector <= VEC_NONE;
      end
    end
  end

  // ==========================================================================
  // Assertions
  read_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    rd_ctrl && !finish && !edge_seen |=> !done_flag_reg) else $error("done flag survived read");
  edge_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
    edge_seen |=> done_flag_reg && up_cnt_reg == 10'h000) else $error("edge not flagged");
  edge_polarity_a: assert property (@(posedge clk) disable iff (!rst_b)
    edge_seen |=> data_bit_reg == $past(capture_input_pin)) else $error("wrong edge polarity");
  edge_count_a: assert property (@(posedge clk) disable iff (!rst_b)
    edge_seen |=> {count_hi_reg, count_low_reg} == $past(up_cnt_reg)) else $error("interval lost");
  take_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
    take_bit |=> buf_flag_reg && down_cnt_reg == $past({count_hi_reg, count_low_reg}))
    else $error("bit take not flagged");
  overflow_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
    overflow |=> buf_flag_reg && up_cnt_reg == 10'h000) else $error("overflow not flagged");
  off_quiet_a: assert property (@(posedge clk) disable iff (!rst_b)
    mode_reg == MODE_OFF |=> !done_flag_reg && !buf_flag_reg) else $error("flag set while off");
  key_value_a: assert property (@(posedge clk) disable iff (!rst_b)
    take_bit && mode_reg == MODE_TRANSMIT |=> tx_key == $past(data_bit_reg)) else $error("key wrong");
  finish_done_a: assert property (@(posedge clk) disable iff (!rst_b)
    finish |=> done_flag_reg && !tx_key) else $error("done not flagged");
  irq_vector_a: assert property (@(posedge clk) disable iff (!rst_b)
    irq_en_reg && done_flag_reg |=> done_edge_irq && irq_vector == VEC_DONE_EDGE)
    else $error("done vector wrong");
endmodule : bit_timer_mark_space
`default_nettype wire

// File: sim/rf_link_model.sv
// Far-side model: times the keying line and drives the capture pin
`timescale 1ns/1ps
`default_nettype none
module rf_link_model (
  input  wire logic        clk,       // System clock
  input  wire logic        rst_b,     // Async reset, active low
  input  wire logic        tx_key,    // Keying from the timer
  output var  logic        pin_out,   // Capture pin drive
  output var  logic [15:0] high_len,  // Last mark length in cycles
  output var  logic [15:0] low_len,   // Last space length in cycles
  output var  logic [7:0]  rise_cnt   // Marks seen
);
  logic        key_q;
  logic [15:0] run_cnt;

  initial pin_out = 1'b0;

  // ==========
  // Run lengths of the keying line
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      key_q    <= 1'b0;
      run_cnt  <= 16'h0000;
      high_len <= 16'h0000;
      low_len  <= 16'h0000;
      rise_cnt <= 8'h00;
    end else if (tx_key !== key_q) begin
      key_q   <= tx_key;
      run_cnt <= 16'h0001;
      if (key_q) begin
        high_len <= run_cnt;
      end else begin
        low_len  <= run_cnt;
        rise_cnt <= rise_cnt + 8'h01;
      end
    end else begin
      run_cnt <= run_cnt + 16'h0001;
    end
  end

  // Edges change only just after a clock edge
  task automatic set_pin(input logic v);
    @(posedge clk);
    pin_out <= v;
  endtask : set_pin
endmodule : rf_link_model
`default_nettype wire

// File: sim/bit_timer_mark_space_bench.sv
// Self-checking bench for the mark/space bit timer
`timescale 1ns/1ps
`default_nettype none
module bit_timer_mark_space_bench;
  import bit_timer_pkg::*;
  localparam logic [11:0] A_CNT = {IDX_COUNT_LOW, 2'b00};
  localparam logic [11:0] A_CTL = {IDX_CONTROL, 2'b00};
  localparam logic [11:0] A_STS = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [11:0] A_MSK = {IDX_IRQ_MASK, 2'b00};
  localparam logic [11:0] A_CFG = {IDX_CPU_CONFIG, 2'b00};
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, pin, tx_key, de_irq, be_irq, irq, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d, c;
  logic [7:0]  irq_vector, rises, r0;
  logic [15:0] hi_len, lo_len;
  int          err_total, num_checks, cyc, t0, i;

  bit_timer_mark_space u_bit_timer_mark_space (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_input_pin(pin), .tx_key(tx_key), .done_edge_irq(de_irq), .buffer_empty_irq(be_irq),
    .irq_vector(irq_vector), .irq(irq));
  rf_link_model u_rf_link_model (.clk(clk), .rst_b(rst_b), .tx_key(tx_key), .pin_out(pin),
    .high_len(hi_len), .low_len(lo_len), .rise_cnt(rises));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  // ==========
  // Bus access and comparison
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    check("pready", {31'h0, pready}, 32'h1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr_reg(input logic [11:0] a, input logic [31:0] v);
    logic [31:0] x;
    logic        y;
    apb(1'b1, a, v, x, y);
  endtask : wr_reg

  task automatic rd_reg(input logic [11:0] a, output logic [31:0] v);
    logic y;
    apb(1'b0, a, 32'h0, v, y);
  endtask : rd_reg

  // Bounded wait for the done (0) or buffer (1) interrupt
  task automatic wait_irq(input logic sel, input int lim);
    for (int n = 0; n < lim && (sel ? be_irq : de_irq) !== 1'b1; n++) @(posedge clk);
    check("irq wait", {31'h0, sel ? be_irq : de_irq}, 32'h1);
  endtask : wait_irq

  task automatic tally_and_finish;
    if (err_total == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    tally_and_finish();
  end

  // ==========
  // Scenarios
  initial begin
    {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
    {err_total, num_checks} = '0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd_reg(A_CNT, d); check("count_low reset", d, 32'h0);
    rd_reg(A_CTL, d); check("control reset", d, 32'h0);
    apb(1'b0, 12'hFF0, 32'h0, d, e); check("unmapped err", {31'h0, e}, 32'h1);
    check("unmapped data", d, 32'h0);
    wr_reg(A_CNT, 32'hA5); rd_reg(A_CNT, d); check("count_low rw", d, 32'hA5);
    apb(1'b1, A_CNT | 12'h001, 32'h5A, d, e); check("misaligned err", {31'h0, e}, 32'h1);
    rd_reg(A_CNT, d); check("misaligned ignored", d, 32'hA5);
    wr_reg(A_CTL, 32'hCD); rd_reg(A_CTL, d); check("control ro", d, 32'hC8);
    wr_reg(A_MSK, 32'h3);
    wr_reg(A_CNT, 32'h0);
    for (i = 0; i < 4; i++) begin
      wr_reg(A_CFG, 32'(i << 5));
      wr_reg(A_CTL, 32'h3A);
      wait_irq(1'b0, 3000);
      check("vector done", {24'h0, irq_vector}, 32'h02);
      check("irq on", {31'h0, irq}, 32'h1);
      rd_reg(A_CTL, d); check("tx flags", d & 32'hFD, 32'h3D);
      check("divided mark", {16'h0, hi_len}, 32'(128 >> i));
      wr_reg(A_STS, 32'h3);
      @(posedge clk);
      check("irq cleared", {31'h0, irq}, 32'h0);
    end
    r0 = rises;
    wr_reg(A_CNT, 32'h2);
    wr_reg(A_CTL, 32'h3A);
    wait_irq(1'b1, 200);
    check("vector buf", {24'h0, irq_vector}, 32'h04);
    rd_reg(A_CTL, d); check("buffer empty", d & 32'h1, 32'h1);
    wr_reg(A_CTL, 32'h38);
    wait_irq(1'b1, 200);
    rd_reg(A_CTL, d);
    wr_reg(A_CTL, 32'h3A);
    wait_irq(1'b0, 400);
    check("mark len", {16'h0, hi_len}, 32'd48);
    check("space len", {16'h0, lo_len}, 32'd48);
    check("mark count", {24'h0, rises}, {24'h0, r0 + 8'h02});
    check("key idle", {31'h0, tx_key}, 32'h0);
    rd_reg(A_CTL, d);
    r0 = rises;
    wr_reg(A_CNT, 32'h0);
    wr_reg(A_CTL, 32'h12);
    repeat (100) @(posedge clk);
    check("generic no irq", {31'h0, de_irq}, 32'h0);
    check("generic no key", {24'h0, rises}, {24'h0, r0});
    rd_reg(A_CTL, d); check("generic flags", d & 32'hFD, 32'h15);
    wr_reg(A_STS, 32'h3);
    wr_reg(A_MSK, 32'h0);
    wr_reg(A_CTL, 32'h28);
    u_rf_link_model.set_pin(1'b1);
    t0 = cyc;
    wait_irq(1'b0, 50);
    rd_reg(A_CTL, d); check("rise edge", d & 32'h36, 32'h26);
    while (cyc < t0 + 87) @(posedge clk);
    u_rf_link_model.set_pin(1'b0);
    wait_irq(1'b0, 50);
    rd_reg(A_CTL, d); check("fall edge", d & 32'h36, 32'h24);
    rd_reg(A_CNT, c);
    c = {22'h0, d[7:6], c[7:0]};
    check("edge interval", {31'h0, c == 32'd5 || c == 32'd6}, 32'h1);
    rd_reg(A_STS, d); check("status sticky", d & 32'h2, 32'h2);
    check("irq masked", {31'h0, irq}, 32'h0);
    wr_reg(A_MSK, 32'h3);
    @(posedge clk);
    check("irq unmasked", {31'h0, irq}, 32'h1);
    wr_reg(A_STS, 32'h3);
    @(posedge clk);
    check("irq w1c", {31'h0, irq}, 32'h0);
    wait_irq(1'b1, 17500);
    check("vector overflow", {24'h0, irq_vector}, 32'h04);
    rd_reg(A_CTL, d); check("overflow flag", d & 32'h1, 32'h1);
    wr_reg(A_CTL, 32'h0);
    u_rf_link_model.set_pin(1'b1);
    repeat (40) @(posedge clk);
    rd_reg(A_CTL, d); check("disabled flags", d, 32'h0);
    check("disabled irq", {31'h0, de_irq}, 32'h0);
    tally_and_finish();
  end
endmodule : bit_timer_mark_space_bench
`default_nettype wire
